//--- hdl/tlic_cfg.svh
// constants for the two-level interrupt controller: register map, bits, vectors
// assumes a 32-bit classic wishbone slave with byte addresses on an 8-bit bus
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH

// register byte offsets, one aligned word each
`define TLIC_ADDR_RSTCTL 8'h00
`define TLIC_ADDR_INTCTL 8'h04
`define TLIC_ADDR_FLAG 8'h08
`define TLIC_ADDR_ENABLE 8'h0c
`define TLIC_ADDR_PRIO 8'h10
`define TLIC_ADDR_STATUS 8'h14

// bit positions
`define TLIC_PRIORITY_LEVELS_ENABLE_BIT 7
`define TLIC_GLOBAL_HIGH_ENABLE_BIT 7
`define TLIC_GLOBAL_LOW_ENABLE_BIT 6
`define TLIC_ST_HIGH_BIT 0
`define TLIC_ST_LOW_BIT 1
`define TLIC_ST_WAKE_BIT 2
`define TLIC_ST_REQ_BIT 3

// reset values
`define TLIC_RST_RSTCTL 8'h00
`define TLIC_RST_INTCTL 8'h00
`define TLIC_RST_PRIO_BIT 1'b1
`define TLIC_RST_VECTOR 16'h0000

// vector addresses
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018

`endif

//--- hdl/tlic_pkg.sv
// types shared by the interrupt controller files
// assumes nothing beyond a SystemVerilog compiler
package tlic_pkg;

	// level of the request currently offered to the core
	typedef enum logic [1:0] {tlic_lvl_none, tlic_lvl_high, tlic_lvl_low} tlic_level_t;

endpackage

//--- hdl/tlic_wb_slave.sv
// classic wishbone slave handshake: one wait state, registered read data
// assumes single classic cycles; the parent decodes the address
`timescale 1ns/1ps

module tlic_wb_slave (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] rd_value,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic wr_take
);

	logic take;

	// a request is taken once; ack drops the cycle after it is given
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// registers are one byte wide, so only lane 0 writes; the write lands at
	// the edge where the master sees ack, while the request is still held
	assign wr_take = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

	// ack and read data share one edge so data is valid with ack
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= take;
			wb_dat_o <= (take & ~wb_we_i) ? rd_value : 32'h0000_0000;
		end
	end

endmodule

//--- hdl/tlic_arbiter.sv
// per-source gating into high and low eligibility for the controller
// assumes flags, enables and priorities come from flip-flops in the parent
`timescale 1ns/1ps

module tlic_arbiter #(
	parameter int NUM_SRC = 8,
	parameter logic [NUM_SRC-1:0] PERIPH_MASK = 8'hf0
) (
	input wire logic [NUM_SRC-1:0] flag,
	input wire logic [NUM_SRC-1:0] enable,
	input wire logic [NUM_SRC-1:0] prio,
	input wire logic priority_levels_enable,
	input wire logic global_high_enable,
	input wire logic global_low_enable,
	input wire logic high_active,
	output logic hi_any,
	output logic lo_any
);

	logic [NUM_SRC-1:0] hi_src;
	logic [NUM_SRC-1:0] lo_src;

	// each source: flag and enable, then the global gate of its level
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
		wire logic armed = flag[i] & enable[i];
		// compatibility: bit 7 gates all, bit 6 gates peripherals only
		wire logic compat_ok = global_high_enable & (~PERIPH_MASK[i] | global_low_enable);
		assign hi_src[i] = armed & (priority_levels_enable
			? (prio[i] & global_high_enable)
			: compat_ok);
		// low level needs both enables and no high routine in progress
		assign lo_src[i] = armed & priority_levels_enable & ~prio[i]
			& global_high_enable & global_low_enable & ~high_active;
	end

	assign hi_any = |hi_src;
	assign lo_any = |lo_src;

endmodule

//--- hdl/tlic_top.sv
// two-level interrupt controller: registers, request to the core, return
// assumes the core gives one-cycle ack and return pulses on sys_clk
// Function
// - high vector is 0008h, low vector is 0018h.
// - a high request may preempt a low service routine in progress.
// - each source has a flag, an enable and a priority bit.
// - two-level operation only while bit 7 of reset control is set.
// - with levels, high enable permits every source whose priority bit is set.
// - with levels, low sources need both low and high global enables.
// - flag, enable and global gate set means vectoring to the chosen vector.
// - levels enable resets clear; priority bits are then ignored.
// - compatibility: bit 6 gates peripherals, bit 7 gates every source.
// - compatibility mode always vectors to 0008h.
// - acceptance clears the global enable that governs the accepted level.
// - no low request is accepted while a high routine is in progress.
// - vectoring pushes the return address and loads the vector into the pc.
// - all flags stay readable so a routine can poll for its sources.
// - return instruction ends the routine and sets back the cleared enable.
// - event to vector takes three to four cycles for edge and port sources.
// - flags set on their event whatever the enables hold.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "tlic_cfg.svh"

module tlic_top #(
	parameter int NUM_SRC = 8,
	parameter logic [NUM_SRC-1:0] PERIPH_MASK = 8'hf0
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_SRC-1:0] src_event,
	output logic core_irq_req,
	output logic [15:0] core_vector,
	input wire logic core_irq_ack,
	input wire logic return_from_service_instr,
	output logic stack_push,
	output logic pc_load,
	output logic [15:0] pc_vector,
	input wire logic core_sleep,
	output logic wake_req
);

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic [7:0] reset_control_reg;
	logic [7:0] interrupt_control_reg;
	logic [NUM_SRC-1:0] flag;
	logic [NUM_SRC-1:0] enable;
	logic [NUM_SRC-1:0] prio;
	logic high_active;
	logic low_active;
	logic hi_q;
	logic lo_q;
	tlic_pkg::tlic_level_t req_level;

	logic priority_levels_enable;
	logic global_high_enable;
	logic global_low_enable;
	logic hi_any;
	logic lo_any;
	logic wr_take;
	logic [31:0] rd_value;

	assign priority_levels_enable = reset_control_reg[`TLIC_PRIORITY_LEVELS_ENABLE_BIT];
	// in compatibility mode these same bits are the global and peripheral enables
	assign global_high_enable = interrupt_control_reg[`TLIC_GLOBAL_HIGH_ENABLE_BIT];
	assign global_low_enable = interrupt_control_reg[`TLIC_GLOBAL_LOW_ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// bus slave and address decode

	tlic_wb_slave u_wb (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i),
		.rd_value(rd_value),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.wr_take(wr_take)
	);

	wire logic hit_rstctl = wb_adr_i == `TLIC_ADDR_RSTCTL;
	wire logic hit_intctl = wb_adr_i == `TLIC_ADDR_INTCTL;
	wire logic hit_flag = wb_adr_i == `TLIC_ADDR_FLAG;
	wire logic hit_enable = wb_adr_i == `TLIC_ADDR_ENABLE;
	wire logic hit_prio = wb_adr_i == `TLIC_ADDR_PRIO;
	wire logic hit_status = wb_adr_i == `TLIC_ADDR_STATUS;

	wire logic wr_rstctl = wr_take & hit_rstctl;
	wire logic wr_intctl = wr_take & hit_intctl;
	wire logic wr_flag = wr_take & hit_flag;
	wire logic wr_enable = wr_take & hit_enable;
	wire logic wr_prio = wr_take & hit_prio;

	// status word: in-service levels, wake and pending request; spare bits read zero
	logic [7:0] status_word;
	always_comb begin
		status_word = 8'h00;
		status_word[`TLIC_ST_HIGH_BIT] = high_active;
		status_word[`TLIC_ST_LOW_BIT] = low_active;
		status_word[`TLIC_ST_WAKE_BIT] = wake_req;
		status_word[`TLIC_ST_REQ_BIT] = core_irq_req;
	end

	// read mux; unmapped addresses answer with zero
	assign rd_value = hit_rstctl ? {24'h000000, reset_control_reg}
		: hit_intctl ? {24'h000000, interrupt_control_reg}
		: hit_flag ? 32'(flag)
		: hit_enable ? 32'(enable)
		: hit_prio ? 32'(prio)
		: hit_status ? {24'h000000, status_word}
		: 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// source flags

	// an event in the same cycle as a software write still leaves the flag set
	wire logic [NUM_SRC-1:0] next_flag = (wr_flag ? wb_dat_i[NUM_SRC-1:0] : flag)
		| src_event;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag <= '0;
			enable <= '0;
			prio <= {NUM_SRC{`TLIC_RST_PRIO_BIT}};
			reset_control_reg <= `TLIC_RST_RSTCTL;
		end else begin
			flag <= next_flag;
			enable <= wr_enable ? wb_dat_i[NUM_SRC-1:0] : enable;
			prio <= wr_prio ? wb_dat_i[NUM_SRC-1:0] : prio;
			reset_control_reg <= wr_rstctl ? wb_dat_i[7:0] : reset_control_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// eligibility

	tlic_arbiter #(
		.NUM_SRC(NUM_SRC),
		.PERIPH_MASK(PERIPH_MASK)
	) u_arb (
		.flag(flag),
		.enable(enable),
		.prio(prio),
		.priority_levels_enable(priority_levels_enable),
		.global_high_enable(global_high_enable),
		.global_low_enable(global_low_enable),
		.high_active(high_active),
		.hi_any(hi_any),
		.lo_any(lo_any)
	);

	////////////////////////////////////////////////////////////////////////////
	// request to the core

	// a request is accepted when the core acks an offered request
	wire logic accept = core_irq_req & core_irq_ack;
	// one registered stage keeps latency fixed; both stages must agree so a
	// gate cleared in between withdraws the request at once
	wire logic hi_go = hi_q & hi_any;
	wire logic lo_go = lo_q & lo_any;
	wire logic next_req = ~accept & (hi_go | lo_go);
	// high wins over low when both are pending
	tlic_pkg::tlic_level_t next_level;
	assign next_level = hi_go ? tlic_pkg::tlic_lvl_high
		: lo_go ? tlic_pkg::tlic_lvl_low
		: tlic_pkg::tlic_lvl_none;
	// compatibility sources are always offered at the high vector
	wire logic [15:0] next_vector = (next_level == tlic_pkg::tlic_lvl_low)
		? `TLIC_VEC_LOW : `TLIC_VEC_HIGH;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			core_irq_req <= 1'b0;
			req_level <= tlic_pkg::tlic_lvl_none;
			core_vector <= `TLIC_RST_VECTOR;
		end else begin
			hi_q <= hi_any;
			lo_q <= lo_any;
			core_irq_req <= next_req;
			req_level <= next_req ? next_level : tlic_pkg::tlic_lvl_none;
			core_vector <= next_req ? next_vector : core_vector;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acceptance and return

	wire logic acc_high = accept & (req_level == tlic_pkg::tlic_lvl_high);
	wire logic acc_low = accept & (req_level == tlic_pkg::tlic_lvl_low);
	// return closes the innermost routine: high first, since it preempted low
	wire logic ret_high = return_from_service_instr & high_active;
	wire logic ret_low = return_from_service_instr & ~high_active & low_active;

	// software write, then hardware clear on acceptance, then the set on
	// return wins so a return in the same cycle is never lost
	wire logic [7:0] ictl_base = wr_intctl ? wb_dat_i[7:0] : interrupt_control_reg;
	wire logic next_global_high_enable = (ictl_base[`TLIC_GLOBAL_HIGH_ENABLE_BIT] & ~acc_high) | ret_high;
	wire logic next_global_low_enable = (ictl_base[`TLIC_GLOBAL_LOW_ENABLE_BIT] & ~acc_low) | ret_low;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_control_reg <= `TLIC_RST_INTCTL;
			high_active <= 1'b0;
			low_active <= 1'b0;
		end else begin
			interrupt_control_reg <= {next_global_high_enable, next_global_low_enable, ictl_base[5:0]};
			high_active <= (high_active & ~ret_high) | acc_high;
			low_active <= (low_active & ~ret_low) | acc_low;
		end
	end

	// on acceptance the core pushes its return address and loads the vector
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stack_push <= 1'b0;
			pc_load <= 1'b0;
			pc_vector <= `TLIC_RST_VECTOR;
		end else begin
			stack_push <= accept;
			pc_load <= accept;
			pc_vector <= accept ? core_vector : pc_vector;
		end
	end

	// wake ignores the global enables so sleep ends even with them clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= core_sleep & (|(flag & enable));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	vector_level_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		core_irq_req |-> (core_vector == ((req_level == tlic_pkg::tlic_lvl_low)
			? `TLIC_VEC_LOW : `TLIC_VEC_HIGH)))
		else $error("vector does not match request level");

	compat_single_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		core_irq_req && !priority_levels_enable && $stable(priority_levels_enable)
		|-> core_vector == `TLIC_VEC_HIGH)
		else $error("compatibility request not at the high vector");

	compat_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!priority_levels_enable && !global_high_enable |-> !hi_any && !lo_any)
		else $error("source eligible with global enable clear");

	event_latency_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(hi_any) && !core_irq_req ##1 hi_any && !core_irq_ack ##1 hi_any
		|-> core_irq_req)
		else $error("request missing after event latency");

	accept_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		acc_high && !wr_intctl && !return_from_service_instr
		|=> !global_high_enable ##1 !core_irq_req)
		else $error("accepted high level left its enable set");

	low_blocked_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		high_active |-> !(core_irq_req && req_level == tlic_pkg::tlic_lvl_low))
		else $error("low request offered during high routine");

	return_restore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ret_high |=> global_high_enable && !high_active)
		else $error("return did not restore high enable");

	flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		|src_event |=> ((flag & $past(src_event)) == $past(src_event)))
		else $error("event did not set its flag");

	high_first_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hi_go && lo_go && !accept |=> core_irq_req && req_level == tlic_pkg::tlic_lvl_high)
		else $error("low served before pending high");

	push_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		accept |=> stack_push && pc_load && pc_vector == $past(core_vector) ##1 !pc_load)
		else $error("vectoring did not push and load once");

	wake_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		core_sleep && (|(flag & enable)) |=> wake_req)
		else $error("wake missing with enabled flag in sleep");

	// gating by mode and level
	levels_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		core_irq_req && req_level == tlic_pkg::tlic_lvl_low |-> $past(priority_levels_enable))
		else $error("low request offered without priority levels");

	high_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		priority_levels_enable && global_high_enable && (|(flag & enable & prio)) |-> hi_any)
		else $error("enabled high source not eligible");

	low_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		priority_levels_enable && !(global_high_enable && global_low_enable) |-> !lo_any)
		else $error("low source eligible without both enables");

	// request lifetime and preemption
	req_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		core_irq_req && !accept && hi_go |=> core_irq_req)
		else $error("pending high request dropped before acceptance");

	req_drop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		accept |=> !core_irq_req)
		else $error("request still offered after acceptance");

	high_preempt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		low_active && hi_go && !accept |=> core_irq_req && req_level == tlic_pkg::tlic_lvl_high)
		else $error("high request held back by low routine");

	// acceptance, return, flags and wake
	low_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		acc_low && !wr_intctl && !return_from_service_instr |=> !global_low_enable)
		else $error("accepted low level left its enable set");

	low_return_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ret_low && !acc_low |=> global_low_enable && !low_active)
		else $error("return did not restore low enable");

	flag_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!wr_flag && !(|src_event) |=> flag == $past(flag))
		else $error("flag changed without event or write");

	push_on_accept_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!accept |=> !stack_push && !pc_load)
		else $error("push or load without acceptance");

	wake_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!core_sleep |=> !wake_req)
		else $error("wake raised while core awake");

endmodule

//--- bench/tlic_core_model.sv
// core sequencer stand-in: takes vectored requests and issues return pulses
// assumes the controller holds its request until accepted or withdrawn
`timescale 1ns/1ps

module tlic_core_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic core_irq_req,
	output logic core_irq_ack,
	output logic return_from_service_instr
);
	int ack_delay = 0; // the bench sets this; 0 answers at once
	int wait_cnt;

	initial return_from_service_instr = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// ack after ack_delay cycles; a withdrawn request restarts the wait, like a busy core
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_irq_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (core_irq_ack || !core_irq_req) begin
			core_irq_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (wait_cnt >= ack_delay) begin
			core_irq_ack <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one-cycle return pulse, launched just after a rising edge
	task automatic do_return();
		@(posedge sys_clk);
		return_from_service_instr <= 1'b1;
		@(posedge sys_clk);
		return_from_service_instr <= 1'b0;
	endtask
endmodule

//--- bench/tlic_top_bench.sv
// self-checking bench: wishbone software side, event pulses, core stand-in
// assumes tlic_top, tlic_core_model and the constants header are compiled first
`timescale 1ns/1ps
`include "tlic_cfg.svh"

module tlic_top_bench;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] src_event = 8'h00;
	logic core_irq_req;
	logic [15:0] core_vector;
	logic core_irq_ack;
	logic return_from_service_instr;
	logic stack_push;
	logic pc_load;
	logic [15:0] pc_vector;
	logic core_sleep = 1'b0;
	logic wake_req;
	int mismatches = 0;
	int check_count = 0;
	int seed = 46;
	int n;
	logic [31:0] rnd;
	logic [31:0] rd_q[$];
	logic [15:0] vec_q[$];

	always #25 sys_clk = ~sys_clk;

	tlic_top dut (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .src_event, .core_irq_req, .core_vector,
		.core_irq_ack, .return_from_service_instr, .stack_push, .pc_load, .pc_vector,
		.core_sleep, .wake_req);
	tlic_core_model core (.sys_clk, .reset_n, .core_irq_req, .core_irq_ack,
		.return_from_service_instr);

	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and hang guard
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// classic single cycle; entered just after an edge, outputs sampled before they update
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel);
		int t;
		t = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1 && t < 20) begin
			@(posedge sys_clk);
			t++;
		end
		if (t >= 20) mismatches++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	// wr gives single bus writes with all four lanes selected; one enable write goes through wb with lane 0 clear, none by block moves
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat, 4'hf);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb(1'b0, adr, 32'h0, 4'hf);
	endtask

	// one-cycle event pulse; n counts edges until the request is seen, then a quiet spell
	task automatic fire(input logic [7:0] m);
		src_event <= m;
		@(posedge sys_clk);
		src_event <= 8'h00;
		n = 1;
		while (core_irq_req !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (12) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watcher: takes the oldest note whenever read data or a vector load shows up
	always @(posedge sys_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
			check("read data", rd_q.pop_front(), wb_dat_o);
		end
		// the vector offered at acceptance must match the note that pc_load will take
		if (core_irq_req === 1'b1 && core_irq_ack === 1'b1 && vec_q.size() > 0)
			check("offered vector", {16'h0, vec_q[0]}, {16'h0, core_vector});
		if (pc_load === 1'b1) begin
			check("stack push", 32'h1, {31'h0, stack_push});
			if (vec_q.size() > 0) check("vector", {16'h0, vec_q.pop_front()}, {16'h0, pc_vector});
			else check("unexpected vector", 32'h0, 32'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: reset values, sleep wake, compatibility, then two levels
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(`TLIC_ADDR_RSTCTL, 32'h0);
		rd(`TLIC_ADDR_INTCTL, 32'h0);
		rd(`TLIC_ADDR_FLAG, 32'h0);
		rd(`TLIC_ADDR_ENABLE, 32'h0);
		rd(`TLIC_ADDR_PRIO, 32'hff);
		rd(`TLIC_ADDR_STATUS, 32'h0);
		rd(8'h18, 32'h0);
		rnd = $random(seed);
		wr(`TLIC_ADDR_ENABLE, rnd);
		wb(1'b1, `TLIC_ADDR_ENABLE, ~rnd, 4'he);
		wr(8'h1c, ~rnd);
		rd(`TLIC_ADDR_ENABLE, {24'h0, rnd[7:0]});
		// sleeping core, global enables clear: flag and wake only
		wr(`TLIC_ADDR_ENABLE, 32'h04);
		core_sleep <= 1'b1;
		fire(8'h04);
		rd(`TLIC_ADDR_STATUS, 32'h04);
		rd(`TLIC_ADDR_FLAG, 32'h04);
		core_sleep <= 1'b0;
		wr(`TLIC_ADDR_FLAG, 32'h0);
		// compatibility: priority bits ignored, bit 6 gates peripherals
		wr(`TLIC_ADDR_ENABLE, 32'hff);
		wr(`TLIC_ADDR_PRIO, 32'h0);
		wr(`TLIC_ADDR_INTCTL, 32'h80);
		fire(8'h10);
		vec_q.push_back(`TLIC_VEC_HIGH);
		fire(8'h01);
		check("latency", 32'h1, 32'(n >= 3 && n <= 4));
		rd(`TLIC_ADDR_INTCTL, 32'h0);
		rd(`TLIC_ADDR_FLAG, 32'h11);
		wr(`TLIC_ADDR_FLAG, 32'h0);
		core.do_return();
		rd(`TLIC_ADDR_INTCTL, 32'h80);
		// slow core; the flag is left set once, so the request comes straight back
		core.ack_delay = 5;
		wr(`TLIC_ADDR_INTCTL, 32'hc0);
		vec_q.push_back(`TLIC_VEC_HIGH);
		vec_q.push_back(`TLIC_VEC_HIGH);
		fire(8'h10);
		core.do_return();
		repeat (14) @(posedge sys_clk);
		wr(`TLIC_ADDR_FLAG, 32'h0);
		core.do_return();
		core.ack_delay = 0;
		// two levels: src0 high, the rest low
		wr(`TLIC_ADDR_RSTCTL, 32'h80);
		wr(`TLIC_ADDR_PRIO, 32'h01);
		wr(`TLIC_ADDR_INTCTL, 32'h80);
		fire(8'h02);
		vec_q.push_back(`TLIC_VEC_HIGH);
		fire(8'h01);
		wr(`TLIC_ADDR_FLAG, 32'h02);
		wr(`TLIC_ADDR_INTCTL, 32'hc0);
		repeat (6) @(posedge sys_clk);
		rd(`TLIC_ADDR_STATUS, 32'h01);
		vec_q.push_back(`TLIC_VEC_LOW);
		core.do_return();
		repeat (12) @(posedge sys_clk);
		rd(`TLIC_ADDR_INTCTL, 32'h80);
		vec_q.push_back(`TLIC_VEC_HIGH);
		fire(8'h01);
		rd(`TLIC_ADDR_STATUS, 32'h03);
		// high and low raised in one cycle: high first, low after the return
		wr(`TLIC_ADDR_FLAG, 32'h0);
		core.do_return();
		core.do_return();
		vec_q.push_back(`TLIC_VEC_HIGH);
		vec_q.push_back(`TLIC_VEC_LOW);
		fire(8'h03);
		wr(`TLIC_ADDR_FLAG, 32'h02);
		core.do_return();
		repeat (12) @(posedge sys_clk);
		check("vectors left", 32'h0, 32'(vec_q.size()));
		print_verdict();
	end
endmodule
